// file: verilog/hbs_sequencer.sv
// Hibernation timer, boot sequencer and one-time-programmable store
// Function
// (R01) The deep sleep domain is a separate always-on block that can shut the chip down through an output feeding the regulator enable.
// (R02) Software loads a wake count and hibernation starts only on a later hibernate request.
// (R03) After the request the standby regulator enable output is held low for exactly the wake count of slow clock cycles.
// (R04) When the wake timer expires the standby regulator enable output goes high again.
// (R05) Only the deep sleep domain keeps its state across hibernation; everything else restarts from reset. The store array is not reset and keeps its bytes.
// (R06) Boot starts when the main regulator enable or the standby wake request is asserted.
// (R07) Boot waits for stable core and io supply regulators before any configuration.
// (R08) Boot then reads the stored bits and applies trimming, package and memory size selection.
// (R09) Boot then powers the application and wireless cores, then the crystal oscillator.
// (R10) Boot finally releases both processors.
// (R11) The store holds 6144 bits, all readable by software after reset.
// (R12) An unprogrammed store reads as all zeros.
// (R13) A bit programmed to one never returns to zero.
// (R14) The store can be programmed whole or byte by byte over many write cycles.
// (R15) Software may keep its own identifiers in the store and read them back after reset.
// (R16) The wake count is 32 bits and a zero count releases the output on the next slow clock cycle.
`timescale 1ns/1ps
module hbs_sequencer
   import hbs_pkg::*;
#(
   parameter int unsigned WAKE_WIDTH = WAKE_W,
   parameter int unsigned ADDR_WIDTH = OTP_ADDR_W,
   parameter int unsigned DEPTH      = OTP_BYTES
) (
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  slow_clk_in,
   input  wire logic                  always_on_reset,
   input  wire logic [WAKE_WIDTH-1:0] wake_count_in,
   input  wire logic                  wake_count_load,
   input  wire logic                  hibernate_request,
   output logic                       standby_regulator_enable_out,
   input  wire logic                  main_regulator_enable_in,
   input  wire logic                  standby_wake_request_in,
   input  wire logic                  core_supply_regulator_ok,
   input  wire logic                  io_supply_regulator_ok,
   output hbs_config_type             boot_config,
   output hbs_power_type              power_ctrl,
   output logic                       boot_done,
   input  wire logic [ADDR_WIDTH-1:0] otp_addr,
   input  wire logic                  otp_read,
   output logic [7:0]                 otp_rdata,
   output logic                       otp_rvalid,
   input  wire logic                  otp_write,
   input  wire logic [7:0]            otp_wdata,
   input  wire logic                  otp_program_all
);
   // Deep sleep domain: reset only by its own always-on reset, not by the chip reset
   hbs_hib_state_type       hib_state_q;
   logic [WAKE_WIDTH-1:0]   wake_count_q;
   logic [WAKE_WIDTH-1:0]   wake_timer_q;
   logic                    standby_out_q;
   logic [2:0]              slow_sync_q;
   logic                    slow_tick;

   // Slow clock is sampled twice before edge detection
   always_ff @(posedge sys_clk or posedge always_on_reset) begin
      if (always_on_reset) begin
         slow_sync_q <= 3'h0;
      end else begin
         slow_sync_q <= {slow_sync_q[1:0], slow_clk_in};
      end
   end
   assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];

   always_ff @(posedge sys_clk or posedge always_on_reset) begin
      if (always_on_reset) begin
         wake_count_q <= '0;
      end else if (wake_count_load && hib_state_q == HBS_HIB_IDLE) begin
         wake_count_q <= wake_count_in; // R02
      end
   end

   always_ff @(posedge sys_clk or posedge always_on_reset) begin // R01 R05
      if (always_on_reset) begin
         hib_state_q   <= HBS_HIB_IDLE;
         wake_timer_q  <= '0;
         standby_out_q <= 1'b1;
      end else begin
         case (hib_state_q)
            HBS_HIB_IDLE: begin
               if (hibernate_request) begin // R02
                  hib_state_q   <= HBS_HIB_LOAD;
                  standby_out_q <= 1'b0; // R03
                  wake_timer_q  <= wake_count_q;
               end
            end
            HBS_HIB_LOAD: begin
               // Count starts on the first slow edge after the request
               if (slow_tick) begin
                  if (wake_timer_q == '0) begin
                     hib_state_q   <= HBS_HIB_IDLE; // R16
                     standby_out_q <= 1'b1;
                  end else if (wake_timer_q == WAKE_ONE) begin
                     hib_state_q   <= HBS_HIB_IDLE;
                     standby_out_q <= 1'b1; // R04
                  end else begin
                     hib_state_q  <= HBS_HIB_COUNT;
                     wake_timer_q <= wake_timer_q - WAKE_ONE; // R03
                  end
               end
            end
            HBS_HIB_COUNT: begin
               if (slow_tick) begin
                  if (wake_timer_q == WAKE_ONE) begin
                     hib_state_q   <= HBS_HIB_IDLE;
                     standby_out_q <= 1'b1; // R04
                  end else begin
                     wake_timer_q <= wake_timer_q - WAKE_ONE; // R03
                  end
               end
            end
            default: begin
               hib_state_q   <= HBS_HIB_IDLE;
               standby_out_q <= 1'b1;
            end
         endcase
      end
   end
   assign standby_regulator_enable_out = standby_out_q;

   // Boot side: board pins pass two flip-flops
   logic [1:0] main_en_sync_q;
   logic [1:0] wake_req_sync_q;
   logic [1:0] core_ok_sync_q;
   logic [1:0] io_ok_sync_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         main_en_sync_q  <= 2'h0;
         wake_req_sync_q <= 2'h0;
         core_ok_sync_q  <= 2'h0;
         io_ok_sync_q    <= 2'h0;
      end else begin
         main_en_sync_q  <= {main_en_sync_q[0], main_regulator_enable_in};
         wake_req_sync_q <= {wake_req_sync_q[0], standby_wake_request_in};
         core_ok_sync_q  <= {core_ok_sync_q[0], core_supply_regulator_ok};
         io_ok_sync_q    <= {io_ok_sync_q[0], io_supply_regulator_ok};
      end
   end

   // Store: array is never reset, so contents survive every chip reset
   logic [7:0]            otp_mem [DEPTH];
   logic [ADDR_WIDTH-1:0] prog_addr_q;
   logic                  prog_all_q;
   logic                  otp_init_q;
   hbs_boot_state_type    boot_state_q;
   hbs_config_type        boot_config_q;
   hbs_power_type         power_q;
   logic [7:0]            otp_rdata_q;
   logic                  otp_rvalid_q;

   function automatic logic [ADDR_WIDTH-1:0] byte_index(input int unsigned idx);
      byte_index = ADDR_WIDTH'(idx);
   endfunction

   // Simulation start: blank array; in silicon the fuses start at zero
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         otp_mem[i] = OTP_BLANK; // R12
      end
   end

   always_ff @(posedge sys_clk) begin
      if (prog_all_q) begin
         otp_mem[prog_addr_q] <= otp_mem[prog_addr_q] | otp_wdata; // R13 R14
      end else if (otp_write && otp_addr < byte_index(DEPTH)) begin
         otp_mem[otp_addr] <= otp_mem[otp_addr] | otp_wdata; // R13 R14
      end
   end

   // Whole-array cycle: same byte pattern streamed to every address in turn
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prog_all_q  <= 1'b0;
         prog_addr_q <= '0;
      end else if (prog_all_q) begin
         if (prog_addr_q == byte_index(DEPTH - 1)) begin
            prog_all_q <= 1'b0;
         end
         prog_addr_q <= prog_addr_q + byte_index(1); // R14
      end else if (otp_program_all) begin
         prog_all_q  <= 1'b1;
         prog_addr_q <= '0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         otp_rdata_q  <= 8'h00;
         otp_rvalid_q <= 1'b0;
      end else begin
         otp_rvalid_q <= otp_read;
         if (otp_read) begin
            otp_rdata_q <= (otp_addr < byte_index(DEPTH)) ? otp_mem[otp_addr] : OTP_BLANK; // R11
         end
      end
   end
   assign otp_rdata  = otp_rdata_q;
   assign otp_rvalid = otp_rvalid_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         boot_state_q  <= HBS_BOOT_OFF;
         boot_config_q <= '0;
         power_q       <= '0;
         otp_init_q    <= 1'b0;
      end else begin
         case (boot_state_q)
            HBS_BOOT_OFF: begin
               if (main_en_sync_q[1] || wake_req_sync_q[1]) begin
                  boot_state_q <= HBS_BOOT_SUPPLY; // R06
               end
            end
            HBS_BOOT_SUPPLY: begin
               if (core_ok_sync_q[1] && io_ok_sync_q[1]) begin
                  boot_state_q <= HBS_BOOT_OTP_TRIM; // R07
               end
            end
            HBS_BOOT_OTP_TRIM: begin
               boot_config_q.trim <= otp_mem[byte_index(TRIM_BYTE)]; // R08
               boot_state_q       <= HBS_BOOT_OTP_PKG;
            end
            HBS_BOOT_OTP_PKG: begin
               boot_config_q.package_sel <= otp_mem[byte_index(PKG_BYTE)]; // R08
               boot_state_q              <= HBS_BOOT_OTP_MEM;
            end
            HBS_BOOT_OTP_MEM: begin
               boot_config_q.memory_size <= otp_mem[byte_index(MEM_BYTE)]; // R08
               otp_init_q                <= 1'b1;
               boot_state_q              <= HBS_BOOT_CORES;
            end
            HBS_BOOT_CORES: begin
               power_q.application_core_on <= 1'b1; // R09
               power_q.wireless_core_on    <= 1'b1;
               boot_state_q                <= HBS_BOOT_XTAL;
            end
            HBS_BOOT_XTAL: begin
               power_q.xtal_on <= 1'b1; // R09
               boot_state_q    <= HBS_BOOT_RELEASE;
            end
            HBS_BOOT_RELEASE: begin
               power_q.application_core_run <= 1'b1; // R10
               power_q.wireless_core_run    <= 1'b1;
            end
            default: begin
               boot_state_q <= HBS_BOOT_OFF;
            end
         endcase
      end
   end

   assign boot_config = boot_config_q;
   assign power_ctrl  = power_q;
   assign boot_done   = otp_init_q & power_q.application_core_run;
endmodule

// file: common/hbs_pkg.sv
// Package for the hibernate and boot sequencer: constants, types, states
package hbs_pkg;
   localparam int unsigned OTP_BITS       = 6144;
   localparam int unsigned OTP_BYTES      = OTP_BITS / 8;
   localparam int unsigned OTP_ADDR_W     = 10;
   localparam int unsigned WAKE_W         = 32;
   localparam int unsigned TRIM_BYTE      = 0;
   localparam int unsigned PKG_BYTE       = 1;
   localparam int unsigned MEM_BYTE       = 2;
   localparam logic [7:0]  OTP_BLANK      = 8'h00;
   localparam logic [WAKE_W-1:0] WAKE_ONE = 32'h0000_0001;

   typedef enum logic [1:0] {
      HBS_HIB_IDLE,
      HBS_HIB_LOAD,
      HBS_HIB_COUNT
   } hbs_hib_state_type;

   typedef enum logic [3:0] {
      HBS_BOOT_OFF,
      HBS_BOOT_SUPPLY,
      HBS_BOOT_OTP_TRIM,
      HBS_BOOT_OTP_PKG,
      HBS_BOOT_OTP_MEM,
      HBS_BOOT_CORES,
      HBS_BOOT_XTAL,
      HBS_BOOT_RELEASE
   } hbs_boot_state_type;

   typedef struct packed {
      logic [7:0] trim;
      logic [7:0] package_sel;
      logic [7:0] memory_size;
   } hbs_config_type;

   typedef struct packed {
      logic application_core_on;
      logic wireless_core_on;
      logic xtal_on;
      logic application_core_run;
      logic wireless_core_run;
   } hbs_power_type;
endpackage

// file: test/hbs_sequencer_checker.sv
// Port checker of the hibernate and boot sequencer
`timescale 1ns/1ps
module hbs_sequencer_checker
   import hbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic slow_clk_in,
   input wire logic always_on_reset,
   input wire logic hibernate_request,
   input wire logic standby_regulator_enable_out,
   input wire logic main_regulator_enable_in,
   input wire logic standby_wake_request_in,
   input wire logic core_supply_regulator_ok,
   input wire logic io_supply_regulator_ok,
   input wire hbs_power_type power_ctrl,
   input wire logic boot_done,
   input wire logic otp_read,
   input wire logic otp_rvalid
);
   default clocking @(posedge sys_clk); endclocking
   // Chip reset follows the standby output, so timer checks use the domain reset only
   default disable iff (reset);
   sequence s_cores; power_ctrl == 5'h18; endsequence
   sequence s_xtal; power_ctrl == 5'h1C && !boot_done; endsequence
   sequence s_run; power_ctrl == 5'h1F && boot_done; endsequence
   property p_rd; otp_read |=> otp_rvalid; endproperty
   property p_rv; otp_rvalid |-> $past(otp_read); endproperty
   property p_sleep; disable iff (always_on_reset)
      hibernate_request && standby_regulator_enable_out |=> !standby_regulator_enable_out;
   endproperty
   property p_wake; disable iff (always_on_reset)
      $rose(standby_regulator_enable_out) |-> $past(slow_clk_in) && !$past(slow_clk_in, 8);
   endproperty
   property p_start; $rose(power_ctrl.application_core_on) |->
      $past(main_regulator_enable_in, 4) || $past(standby_wake_request_in, 4); endproperty
   property p_supply; $rose(power_ctrl.application_core_on) |->
      core_supply_regulator_ok && io_supply_regulator_ok; endproperty
   property p_order;
      $rose(power_ctrl.application_core_on) |-> s_cores ##1 s_xtal ##1 s_run;
   endproperty
   property p_done; boot_done |=> boot_done; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   a_rv: assert property (p_rv) else $error("stray read valid");
   a_sleep: assert property (p_sleep) else $error("hibernate not started");
   a_wake: assert property (p_wake) else $error("wake off slow tick");
   a_start: assert property (p_start) else $error("boot without enable");
   a_supply: assert property (p_supply) else $error("boot before supplies");
   a_order: assert property (p_order) else $error("power up order wrong");
   a_done: assert property (p_done) else $error("boot done dropped");
endmodule
bind hbs_sequencer hbs_sequencer_checker i_hbs_sequencer_checker (.sys_clk, .reset,
   .slow_clk_in, .always_on_reset, .hibernate_request, .standby_regulator_enable_out,
   .main_regulator_enable_in, .standby_wake_request_in, .core_supply_regulator_ok,
   .io_supply_regulator_ok, .power_ctrl, .boot_done, .otp_read, .otp_rvalid);

// file: test/hbs_board_model.sv
// Board model: regulator wiring, supply regulators and 32 kHz crystal
`timescale 1ns/1ps
module hbs_board_model #(
   parameter int unsigned OK_DELAY = 20
) (
   input  wire logic sys_clk,
   input  wire logic bench_reset,
   input  wire logic main_hold,
   input  wire logic standby_regulator_enable_out,
   output logic      slow_clk_in,
   output logic      reset,
   output logic      main_regulator_enable_in,
   output logic      core_supply_regulator_ok,
   output logic      io_supply_regulator_ok
);
   int unsigned ramp_q;
   // Crystal runs free; odd offset keeps its edges off the fast clock edges
   initial begin
      slow_clk_in = 1'h0;
      #1.3;
      forever #15625 slow_clk_in = ~slow_clk_in;
   end
   // Hold lets the bench keep the main enable off so the wake pin alone starts boot
   assign main_regulator_enable_in = standby_regulator_enable_out && !main_hold;
   assign reset = bench_reset || !standby_regulator_enable_out;
   // Core supply settles first, io supply later
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ramp_q <= 0;
      end else if (ramp_q < OK_DELAY) begin
         ramp_q <= ramp_q + 1;
      end
   end
   assign core_supply_regulator_ok = (ramp_q >= OK_DELAY / 2);
   assign io_supply_regulator_ok = (ramp_q >= OK_DELAY);
endmodule

// file: test/hibernate_boot_sequencer_tb.sv
// Self-checking bench of the hibernate and boot sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED at %0t: got %h want %h", $time, (a), (b)); end end
module hibernate_boot_sequencer_tb
   import hbs_pkg::*;
;
   logic sys_clk = 0, bench_reset = 1, always_on_reset = 1, slow_clk_in, reset;
   logic wake_count_load = 0, hibernate_request = 0, standby_wake_request_in = 0;
   logic main_hold = 0;
   logic standby_regulator_enable_out, main_regulator_enable_in, boot_done, otp_rvalid;
   logic core_supply_regulator_ok, io_supply_regulator_ok;
   logic otp_read = 0, otp_write = 0, otp_program_all = 0;
   logic [31:0] wake_count_in = 0;
   logic [9:0] otp_addr = 0;
   logic [7:0] otp_wdata = 0, otp_rdata;
   hbs_config_type boot_config;
   hbs_power_type power_ctrl;
   int n_mismatch = 0, cmp_count = 0, cycles = 0;

   hbs_sequencer i_hbs_sequencer (.sys_clk, .reset, .slow_clk_in, .always_on_reset,
      .wake_count_in, .wake_count_load, .hibernate_request, .standby_regulator_enable_out,
      .main_regulator_enable_in, .standby_wake_request_in, .core_supply_regulator_ok,
      .io_supply_regulator_ok, .boot_config, .power_ctrl, .boot_done, .otp_addr,
      .otp_read, .otp_rdata, .otp_rvalid, .otp_write, .otp_wdata, .otp_program_all);
   hbs_board_model i_hbs_board_model (.sys_clk, .bench_reset, .main_hold,
      .standby_regulator_enable_out, .slow_clk_in, .reset, .main_regulator_enable_in,
      .core_supply_regulator_ok, .io_supply_regulator_ok);

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic results();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic otp_wr(input logic [9:0] a, input logic [7:0] d, input logic all);
      @(posedge sys_clk);
      otp_addr <= a;
      otp_wdata <= d;
      otp_write <= !all;
      otp_program_all <= all;
      @(posedge sys_clk);
      otp_write <= 1'h0;
      otp_program_all <= 1'h0;
   endtask

   task automatic otp_rd(input logic [9:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      otp_addr <= a;
      otp_read <= 1'h1;
      @(posedge sys_clk);
      otp_read <= 1'h0;
      #1;
      `CHK(otp_rvalid, 1'h1)
      `CHK(otp_rdata, d)
   endtask

   task automatic t_boot();
      for (int i = 0; i < 300 && boot_done !== 1'h1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      `CHK(boot_done, 1'h1)
      `CHK(power_ctrl, 5'h1F)
      $display("boot test done");
   endtask

   task automatic t_otp();
      otp_rd(10'h000, 8'h00);
      otp_rd(10'h2FF, 8'h00);
      otp_rd(10'h300, 8'h00);
      otp_wr(10'h000, 8'h5A, 1'h0);
      otp_wr(10'h001, 8'h03, 1'h0);
      otp_wr(10'h002, 8'h0C, 1'h0);
      otp_wr(10'h2BC, 8'hA5, 1'h0);
      otp_wr(10'h000, 8'h81, 1'h0);
      otp_rd(10'h000, 8'hDB);
      otp_wr(10'h000, 8'h20, 1'h1);
      repeat (770) @(posedge sys_clk);
      otp_rd(10'h000, 8'hFB);
      otp_rd(10'h2FF, 8'h20);
      $display("otp test done");
   endtask

   task automatic t_hib(input logic [31:0] n);
      int ticks;
      ticks = 0;
      @(posedge sys_clk);
      wake_count_in <= n;
      wake_count_load <= 1'h1;
      @(posedge sys_clk);
      wake_count_load <= 1'h0;
      // Request just after a pin edge, so no tick is in flight through the sync
      @(posedge slow_clk_in);
      `CHK(standby_regulator_enable_out, 1'h1)
      repeat (10) @(posedge sys_clk);
      hibernate_request <= 1'h1;
      @(posedge sys_clk);
      hibernate_request <= 1'h0;
      #1;
      `CHK(standby_regulator_enable_out, 1'h0)
      `CHK(boot_done, 1'h0)
      while (standby_regulator_enable_out !== 1'h1 && ticks < 9) begin
         @(posedge slow_clk_in or posedge standby_regulator_enable_out);
         if (standby_regulator_enable_out !== 1'h1) begin
            ticks++;
         end
      end
      `CHK(ticks, (n == 0) ? 1 : int'(n))
      t_boot();
      `CHK(boot_config, 24'hFB_232C)
      otp_rd(10'h2BC, 8'hA5);
      $display("hibernate test done");
   endtask

   task automatic t_pin();
      // Main enable held off: only the wake request pin may start boot
      @(posedge sys_clk);
      main_hold <= 1'h1;
      bench_reset <= 1'h1;
      repeat (16) @(posedge sys_clk);
      bench_reset <= 1'h0;
      repeat (100) @(posedge sys_clk);
      #1;
      `CHK(power_ctrl, 5'h00)
      `CHK(boot_done, 1'h0)
      @(posedge sys_clk);
      standby_wake_request_in <= 1'h1;
      t_boot();
      `CHK(boot_config, 24'hFB_232C)
      $display("wake pin test done");
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      bench_reset <= 1'h0;
      always_on_reset <= 1'h0;
      t_boot();
      `CHK(boot_config, 24'h00_0000)
      t_otp();
      t_hib(32'h0000_0000);
      t_hib(32'h0000_0003);
      t_pin();
      results();
   end
endmodule
